// [dbu_defs.svh]
`ifndef DBU_DEFS_SVH
`define DBU_DEFS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define DBU_OFF_ADDR0        8'h00
`define DBU_OFF_ADDR1        8'h04
`define DBU_OFF_ADDR2        8'h08
`define DBU_OFF_ADDR3        8'h0c
`define DBU_OFF_STATUS       8'h18
`define DBU_OFF_CONTROL      8'h1c

// ****************************************************************
// Field positions.
// ****************************************************************
`define DBU_CTL_GD           13
`define DBU_CTL_FIELD_LSB    16
`define DBU_CTL_SLOT_STRIDE  4
`define DBU_ST_BS            14
`define DBU_ST_BT            15

// ****************************************************************
// Reset values and writable masks.
// ****************************************************************
`define DBU_STATUS_RESET     32'h0000_0000
`define DBU_CONTROL_RESET    32'h0000_0000
`define DBU_ADDR_RESET       32'h0000_0000
`define DBU_STATUS_WMASK     32'h0000_c00f
`define DBU_CONTROL_WMASK    32'hffff_20ff

// ****************************************************************
// Field encodings.
// ****************************************************************
`define DBU_TYPE_EXEC        2'b00
`define DBU_TYPE_WRITE       2'b01
`define DBU_TYPE_RDWR        2'b11
`define DBU_LEN_ONE          2'b00
`define DBU_LEN_TWO          2'b01
`define DBU_LEN_FOUR         2'b11

`endif

// [dbu_pkg.sv]
package dbu_pkg;

  // Kind of access reported by the pipeline.
  typedef enum logic [1:0] {
    DBU_ACC_EXEC  = 2'b00,
    DBU_ACC_WRITE = 2'b01,
    DBU_ACC_READ  = 2'b10
  } dbu_acc_kind_t;

  // One register word.
  typedef logic [31:0] dbu_word_t;

endpackage

// [dbu_access_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Carries one pipeline access to the slot comparators.
interface dbu_access_if;
  import dbu_pkg::*;
  logic          valid;
  dbu_word_t     addr;
  dbu_acc_kind_t kind;
  logic [1:0]    size;

  modport src (output valid, output addr, output kind, output size);
  modport mon (input valid, input addr, input kind, input size);
endinterface

`default_nettype wire

// [dbu_slot_match.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dbu_defs.svh"

module dbu_slot_match
  import dbu_pkg::*;
(
  // Access under test.
  dbu_access_if.mon  acc,
  // Slot settings.
  input  wire logic [31:0] slot_linear_address,
  input  wire logic [1:0]  slot_access_type,
  input  wire logic [1:0]  slot_match_length,
  // Match result.
  output logic             hit
);

  logic [31:0] span_mask;
  logic [32:0] bp_lo;
  logic [32:0] bp_hi;
  logic [32:0] acc_lo;
  logic [32:0] acc_hi;
  logic        len_ok;
  logic        type_ok;

  // Length selects how many low address bits are ignored.
  always_comb begin
    unique case (slot_match_length)
      `DBU_LEN_ONE:  span_mask = 32'hffff_ffff; // see RQ7
      `DBU_LEN_TWO:  span_mask = 32'hffff_fffe; // see RQ7
      `DBU_LEN_FOUR: span_mask = 32'hffff_fffc; // see RQ7
      default:       span_mask = 32'hffff_ffff;
    endcase
  end

  // The unused length code never matches.
  assign len_ok = (slot_match_length != 2'b10); // see RQ7

  // Access type against slot type; the unused type code never matches.
  always_comb begin
    unique case (slot_access_type)
      `DBU_TYPE_EXEC:  type_ok = (acc.kind == DBU_ACC_EXEC); // see RQ6
      `DBU_TYPE_WRITE: type_ok = (acc.kind == DBU_ACC_WRITE); // see RQ6
      `DBU_TYPE_RDWR:  type_ok = (acc.kind == DBU_ACC_WRITE) ||
                                 (acc.kind == DBU_ACC_READ); // see RQ6
      default:         type_ok = 1'b0;
    endcase
  end

  // Byte spans held one bit wider so the top of memory does not wrap.
  assign bp_lo  = {1'b0, slot_linear_address & span_mask};
  assign bp_hi  = {1'b0, slot_linear_address | ~span_mask};
  assign acc_lo = {1'b0, acc.addr};
  assign acc_hi = acc_lo + {31'h0000_0000, acc.size};

  // A hit is any overlap of the two spans.
  assign hit = acc.valid && len_ok && type_ok &&
               (acc_lo <= bp_hi) && (bp_lo <= acc_hi);

endmodule

`default_nettype wire

// [dbu_exc_gen.sv]
`timescale 1ns/1ps
`default_nettype none

module dbu_exc_gen (
  // Instruction completion.
  input  wire logic       ret_valid,
  input  wire logic       single_step_trap_flag,
  input  wire logic       bkpt_insn,
  // Pending causes.
  input  wire logic [3:0] hits_now,
  input  wire logic [3:0] slot_enabled,
  input  wire logic       task_trap_now,
  // Decisions.
  output logic            take_debug,
  output logic            take_bkpt
);

  // Debug exception causes are checked only at instruction completion.
  assign take_debug = ret_valid &&
                      (single_step_trap_flag || // see RQ1
                       (|(hits_now & slot_enabled)) || // see RQ11
                       task_trap_now);

  // The one-byte breakpoint instruction takes its own trap path.
  assign take_bkpt = ret_valid && bkpt_insn; // see RQ2

endmodule

`default_nettype wire

// [dbu_top.sv]
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dbu_defs.svh"

// Contract
// RQ1: With the single-step trap flag set, a debug exception follows each completed instruction.
// RQ2: The one-byte breakpoint instruction sends control to the debug path when it executes.
// RQ3: At a debug exception, each slot whose condition matched sets its hit flag, enabled or not.
// RQ4: The task-switch flag is set before the handler when a switch entered a trapped task.
// RQ5: The single-step flag is set when the exception was caused by single-stepping.
// RQ6: Slot access type: 00 execute only, 01 writes only, 11 reads or writes, 10 unused.
// RQ7: Slot length: 00 one byte, 01 two bytes, 11 four bytes, 10 unused.
// RQ8: A slot's global enable arms it for all tasks and survives task switches.
// RQ9: A slot's local enable arms it for the current task and is cleared on a task switch.
// RQ10: The general-detect lock blocks debug register access and is cleared on a debug exception.
// RQ11: A match on an enabled slot raises a debug exception; on a disabled slot it only sets status.
// Here a disabled-slot match reaches status only when a debug exception is taken.
module dbu_top
  import dbu_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,

  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,

  // Memory access report from the pipeline.
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_addr,
  input  wire logic [1:0]  acc_kind,
  input  wire logic [1:0]  acc_size,

  // Instruction completion report.
  input  wire logic        ret_valid,
  input  wire logic        ret_single_step_trap_flag,
  input  wire logic        ret_bkpt_insn,

  // Task switch report.
  input  wire logic        ts_valid,
  input  wire logic        ts_trap,

  // Exception requests to the pipeline.
  output logic             debug_exc,
  output logic             bkpt_exc
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  // Register state.
  dbu_word_t   addr_reg [4];
  dbu_word_t   debug_status_reg;
  dbu_word_t   debug_status_next;
  dbu_word_t   debug_control_reg;
  dbu_word_t   debug_control_next;
  logic [3:0]  pend_hit_reg;
  logic        task_trap_reg;

  // Comparator and decision nets.
  logic [3:0]  slot_hit;
  logic [3:0]  hits_now;
  logic [3:0]  slot_enabled;
  logic        task_trap_now;
  logic        take_debug;
  logic        take_bkpt;

  // Register bus decode.
  logic        apb_setup;
  logic        apb_access;
  logic        apb_wr;
  logic        addr_known;
  logic        addr_is_slot;
  logic        locked;
  logic        refuse;
  logic        wr_status;
  logic        wr_control;
  dbu_word_t   rd_value;

  // Carries the pipeline access to all four comparators.
  dbu_access_if acc_bus ();

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // Access type field of one slot.
  function automatic logic [1:0] slot_type(input dbu_word_t ctl, input int slot);
    int lsb;

    lsb = `DBU_CTL_FIELD_LSB + slot * `DBU_CTL_SLOT_STRIDE;
    return ctl[lsb +: 2];
  endfunction

  // Length field of one slot.
  function automatic logic [1:0] slot_len(input dbu_word_t ctl, input int slot);
    int lsb;

    lsb = `DBU_CTL_FIELD_LSB + slot * `DBU_CTL_SLOT_STRIDE + 2;
    return ctl[lsb +: 2];
  endfunction

  // Merge a software write into a register under a writable mask.
  function automatic dbu_word_t masked_write(input dbu_word_t old_val,
                                             input dbu_word_t new_val,
                                             input dbu_word_t wmask);
    return (old_val & ~wmask) | (new_val & wmask);
  endfunction

  // ****************************************************************
  // Access path into the slot comparators.
  // ****************************************************************

  // The pipeline runs on pclk, so its reports are used as they arrive.
  assign acc_bus.valid = acc_valid;
  assign acc_bus.addr  = acc_addr;
  assign acc_bus.kind  = dbu_acc_kind_t'(acc_kind);
  assign acc_bus.size  = acc_size;

  // One comparator per slot, each fed by its own control fields.
  for (genvar i = 0; i < 4; i++) begin : g_slot
    dbu_slot_match u_match (
      .acc                 (acc_bus.mon),
      .slot_linear_address (addr_reg[i]),
      .slot_access_type    (slot_type(debug_control_reg, i)),
      .slot_match_length   (slot_len(debug_control_reg, i)),
      .hit                 (slot_hit[i])
    );

    // A slot is armed by either its local or its global enable.
    assign slot_enabled[i] = debug_control_reg[2 * i] |
                             debug_control_reg[2 * i + 1]; // see RQ8 see RQ9
  end

  // ****************************************************************
  // Exception decision.
  // ****************************************************************

  // Matches seen this cycle join those gathered earlier in the instruction.
  assign hits_now      = pend_hit_reg | slot_hit;

  // A trapped switch counts even in its completing cycle.
  assign task_trap_now = task_trap_reg | (ts_valid & ts_trap);

  dbu_exc_gen u_exc (
    .ret_valid             (ret_valid),
    .single_step_trap_flag (ret_single_step_trap_flag),
    .bkpt_insn             (ret_bkpt_insn),
    .hits_now              (hits_now),
    .slot_enabled          (slot_enabled),
    .task_trap_now         (task_trap_now),
    .take_debug            (take_debug),
    .take_bkpt             (take_bkpt)
  );

  // Matches are gathered until the instruction completes, then dropped.
  // A hit in the completing cycle itself reaches the decision via hits_now.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_hit_reg <= 4'h0;
    end else if (ret_valid) begin
      pend_hit_reg <= 4'h0;
    end else begin
      pend_hit_reg <= hits_now; // see RQ3
    end
  end

  // A switch into a trapped task is held until the next completion.
  // The trap bit means nothing unless ts_valid is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      task_trap_reg <= 1'b0;
    end else if (ret_valid) begin
      task_trap_reg <= 1'b0;
    end else begin
      task_trap_reg <= task_trap_now; // see RQ4
    end
  end

  // Debug exception request, a registered one-cycle pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_exc <= 1'b0;
    end else begin
      debug_exc <= take_debug; // see RQ1 see RQ11
    end
  end

  // Breakpoint trap request, a registered one-cycle pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bkpt_exc <= 1'b0;
    end else begin
      bkpt_exc <= take_bkpt; // see RQ2
    end
  end

  // ****************************************************************
  // APB decode.
  // ****************************************************************

  // The slave never waits.
  assign pready     = 1'b1;

  // Phase of the current transfer.
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;

  // Known offsets and the slot address subset.
  assign addr_is_slot = (paddr == `DBU_OFF_ADDR0) || (paddr == `DBU_OFF_ADDR1) ||
                        (paddr == `DBU_OFF_ADDR2) || (paddr == `DBU_OFF_ADDR3);
  assign addr_known   = addr_is_slot || (paddr == `DBU_OFF_STATUS) ||
                        (paddr == `DBU_OFF_CONTROL);

  // The lock turns every debug register access into an error.
  assign locked  = debug_control_reg[`DBU_CTL_GD]; // see RQ10
  assign refuse  = ~addr_known | locked;
  assign pslverr = apb_access & refuse;
  assign apb_wr  = apb_access & pwrite & ~refuse;

  // Write strobes of the two debug words.
  assign wr_status  = apb_wr & (paddr == `DBU_OFF_STATUS);
  assign wr_control = apb_wr & (paddr == `DBU_OFF_CONTROL);

  // Read mux; unmapped and locked reads return zero.
  always_comb begin
    rd_value = 32'h0000_0000;

    if (!locked) begin
      unique case (paddr)
        `DBU_OFF_ADDR0:   rd_value = addr_reg[0];
        `DBU_OFF_ADDR1:   rd_value = addr_reg[1];
        `DBU_OFF_ADDR2:   rd_value = addr_reg[2];
        `DBU_OFF_ADDR3:   rd_value = addr_reg[3];
        `DBU_OFF_STATUS:  rd_value = debug_status_reg;
        `DBU_OFF_CONTROL: rd_value = debug_control_reg;
        default:          rd_value = 32'h0000_0000;
      endcase
    end
  end

  // Read data is captured in the setup phase and held for the access phase.
  // Capturing early keeps prdata a flip-flop output with no bus-side mux.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_value;
    end
  end

  // ****************************************************************
  // Slot address registers.
  // ****************************************************************

  // Written by software only; the slot index comes from offset bits 3:2.
  // Slot addresses have no reserved bits, so the whole word is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        addr_reg[i] <= `DBU_ADDR_RESET;
      end
    end else if (apb_wr && addr_is_slot) begin
      addr_reg[paddr[3:2]] <= pwdata;
    end
  end

  // ****************************************************************
  // Status register.
  // ****************************************************************

  // Software write first, then hardware sets, so a set is never lost.
  always_comb begin
    debug_status_next = debug_status_reg;

    if (wr_status) begin
      debug_status_next = masked_write(debug_status_reg, pwdata, `DBU_STATUS_WMASK);
    end

    // Causes of the exception being taken are recorded last.
    if (take_debug) begin
      debug_status_next[3:0] = debug_status_next[3:0] | hits_now; // see RQ3
      if (ret_single_step_trap_flag) begin
        debug_status_next[`DBU_ST_BS] = 1'b1; // see RQ5
      end
      if (task_trap_now) begin
        debug_status_next[`DBU_ST_BT] = 1'b1; // see RQ4
      end
    end
  end

  // Status storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_status_reg <= `DBU_STATUS_RESET;
    end else begin
      debug_status_reg <= debug_status_next;
    end
  end

  // ****************************************************************
  // Control register.
  // ****************************************************************

  // Software write first, then the hardware clears take priority.
  always_comb begin
    debug_control_next = debug_control_reg;

    if (wr_control) begin
      debug_control_next = masked_write(debug_control_reg, pwdata, `DBU_CONTROL_WMASK);
    end

    // Task switch drops local enables and keeps global ones.
    if (ts_valid) begin
      for (int i = 0; i < 4; i++) begin
        debug_control_next[2 * i] = 1'b0; // see RQ9 see RQ8
      end
    end

    // Taking a debug exception releases the lock for the handler.
    if (take_debug) begin
      debug_control_next[`DBU_CTL_GD] = 1'b0; // see RQ10
    end
  end

  // Control storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_control_reg <= `DBU_CONTROL_RESET;
    end else begin
      debug_control_reg <= debug_control_next;
    end
  end

endmodule

`default_nettype wire

// [dbu_top_props.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Port checker for the debug breakpoint unit.
// ****************************************************************
module dbu_top_props (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // APB.
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  // Pipeline reports.
  input wire logic       ret_valid,
  input wire logic       ret_single_step_trap_flag,
  input wire logic       ret_bkpt_insn,
  input wire logic       ts_valid,
  input wire logic       ts_trap,
  // Exception requests.
  input wire logic       debug_exc,
  input wire logic       bkpt_exc
);
  logic trap_pend_reg;
  logic lock_free_reg;
  logic ctl_wr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A write to the control word may set the lock again.
  assign ctl_wr = psel && penable && pwrite && (paddr == 8'h1c);

  // Remembers a trapped task switch until its instruction ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      trap_pend_reg <= 1'b0;
    else if (ret_valid)
      trap_pend_reg <= 1'b0;
    else if (ts_valid && ts_trap)
      trap_pend_reg <= 1'b1;
  end

  // Knows the lock is clear after a debug exception until control is written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lock_free_reg <= 1'b1;
    else if (ctl_wr)
      lock_free_reg <= 1'b0;
    else if (debug_exc)
      lock_free_reg <= 1'b1;
  end

  a_step_raises_exc: assert property (ret_valid && ret_single_step_trap_flag |=> debug_exc)
    else $error("single step gave no debug exception");
  a_bkpt_raises_trap: assert property (ret_valid && ret_bkpt_insn |=> bkpt_exc)
    else $error("breakpoint instruction gave no trap");
  a_bkpt_has_cause: assert property (bkpt_exc |-> $past(ret_valid) && $past(ret_bkpt_insn))
    else $error("breakpoint trap without breakpoint instruction");
  a_exc_has_retire: assert property (debug_exc |-> $past(ret_valid))
    else $error("debug exception without completed instruction");
  a_exc_one_cycle: assert property (debug_exc && !ret_valid |=> !debug_exc)
    else $error("debug exception longer than one cycle");
  a_trap_switch_exc: assert property (
    ret_valid && (trap_pend_reg || (ts_valid && ts_trap)) |=> debug_exc)
    else $error("trapped task switch gave no debug exception");
  a_lock_cleared: assert property (
    psel && penable && lock_free_reg && (paddr == 8'h1c || paddr == 8'h18) |-> !pslverr)
    else $error("debug register refused after debug exception");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
endmodule

bind dbu_top dbu_top_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pslverr(pslverr), .ret_valid(ret_valid),
  .ret_single_step_trap_flag(ret_single_step_trap_flag), .ret_bkpt_insn(ret_bkpt_insn),
  .ts_valid(ts_valid), .ts_trap(ts_trap), .debug_exc(debug_exc), .bkpt_exc(bkpt_exc)
);

`default_nettype wire

// [dbu_pipe_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Instruction pipeline model that reports accesses and retirements.
// ****************************************************************
module dbu_pipe_model (
  // Clock.
  input wire logic   pclk,
  // Reports to the unit.
  output var logic        acc_valid,
  output var logic [31:0] acc_addr,
  output var logic [1:0]  acc_kind,
  output var logic [1:0]  acc_size,
  output var logic        ret_valid,
  output var logic        ret_flag,
  output var logic        ret_bkpt,
  output var logic        ts_valid,
  output var logic        ts_trap
);
  // Idle reports at time zero.
  initial begin
    acc_valid = 1'b0;
    acc_addr  = 32'h0;
    acc_kind  = 2'h0;
    acc_size  = 2'h0;
    ret_valid = 1'b0;
    ret_flag  = 1'b0;
    ret_bkpt  = 1'b0;
    ts_valid  = 1'b0;
    ts_trap   = 1'b0;
  end

  // One access for one cycle; the released address shows the inverse value.
  task automatic access(input logic [31:0] a, input logic [1:0] k, input logic [1:0] s);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_addr  <= a;
    acc_kind  <= k;
    acc_size  <= s;
    @(posedge pclk);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
  endtask

  // One completed instruction with its single-step flag.
  task automatic retire(input logic step, input logic bkpt);
    @(posedge pclk);
    ret_valid <= 1'b1;
    ret_flag  <= step;
    ret_bkpt  <= bkpt;
    @(posedge pclk);
    ret_valid <= 1'b0;
    ret_flag  <= ~step;
    ret_bkpt  <= ~bkpt;
  endtask

  // One task switch.
  task automatic tswitch(input logic trap);
    @(posedge pclk);
    ts_valid <= 1'b1;
    ts_trap  <= trap;
    @(posedge pclk);
    ts_valid <= 1'b0;
    ts_trap  <= ~trap;
  endtask
endmodule

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dbu_defs.svh"

// ****************************************************************
// Self-checking bench for the debug breakpoint unit.
// ****************************************************************
module testbench;
  import dbu_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        acc_valid;
  logic [31:0] acc_addr;
  logic [1:0]  acc_kind;
  logic [1:0]  acc_size;
  logic        ret_valid;
  logic        ret_flag;
  logic        ret_bkpt;
  logic        ts_valid;
  logic        ts_trap;
  logic        debug_exc;
  logic        bkpt_exc;
  int          errors;
  int          samples_checked;
  int          n_dbg;
  int          n_bkpt;

  dbu_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind), .acc_size(acc_size),
    .ret_valid(ret_valid), .ret_single_step_trap_flag(ret_flag), .ret_bkpt_insn(ret_bkpt),
    .ts_valid(ts_valid), .ts_trap(ts_trap), .debug_exc(debug_exc), .bkpt_exc(bkpt_exc)
  );

  dbu_pipe_model u_pipe (
    .pclk(pclk), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind),
    .acc_size(acc_size), .ret_valid(ret_valid), .ret_flag(ret_flag), .ret_bkpt(ret_bkpt),
    .ts_valid(ts_valid), .ts_trap(ts_trap)
  );

  // Clock of 100 MHz.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Counts exception pulses.
  always @(posedge pclk) begin
    if (debug_exc === 1'b1)
      n_dbg++;
    if (bkpt_exc === 1'b1)
      n_bkpt++;
  end

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares one value.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; on a read d is the expected data.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      summarize();
    end
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    if (!wr)
      chk("prdata", d, prdata);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b0, a, d, err);
  endtask

  // Retires one instruction and checks the exception pulses it gives.
  task automatic run(input logic step, input logic bkpt, input int ed, input int eb);
    int d0;
    int b0;
    d0 = n_dbg;
    b0 = n_bkpt;
    u_pipe.retire(step, bkpt);
    repeat (2) @(posedge pclk);
    chk("debug_exc count", 32'(ed), 32'(n_dbg - d0));
    chk("bkpt_exc count", 32'(eb), 32'(n_bkpt - b0));
  endtask

  // Programs slot 0 globally, makes one access and checks hit and status.
  task automatic match_case(input logic [1:0] ty, input logic [1:0] ln, input logic [1:0] kd,
                            input logic [31:0] ad, input logic [1:0] sz, input logic hit);
    wr(`DBU_OFF_CONTROL, {12'h0, ln, ty, 16'h0002});
    u_pipe.access(ad, kd, sz);
    run(1'b0, 1'b0, int'(hit), 0);
    rd(`DBU_OFF_STATUS, {31'h0, hit}, 1'b0);
    wr(`DBU_OFF_STATUS, 32'h0);
  endtask

  // Main sequence.
  initial begin
    errors = 0;
    samples_checked = 0;
    n_dbg = 0;
    n_bkpt = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DBU_OFF_CONTROL, 32'h0, 1'b0);
    rd(`DBU_OFF_STATUS, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    wr(`DBU_OFF_ADDR0, 32'h0000_0100);
    wr(`DBU_OFF_ADDR1, 32'h0000_0200);
    rd(`DBU_OFF_ADDR1, 32'h0000_0200, 1'b0);
    wr(`DBU_OFF_CONTROL, 32'hffff_dfff);
    rd(`DBU_OFF_CONTROL, 32'hffff_00ff, 1'b0);
    match_case(2'b00, 2'b00, DBU_ACC_EXEC, 32'h100, 2'd0, 1'b1);
    match_case(2'b00, 2'b00, DBU_ACC_WRITE, 32'h100, 2'd0, 1'b0);
    match_case(2'b01, 2'b01, DBU_ACC_WRITE, 32'h101, 2'd0, 1'b1);
    match_case(2'b01, 2'b00, DBU_ACC_WRITE, 32'h101, 2'd0, 1'b0);
    match_case(2'b01, 2'b00, DBU_ACC_READ, 32'h100, 2'd0, 1'b0);
    match_case(2'b11, 2'b11, DBU_ACC_READ, 32'h103, 2'd0, 1'b1);
    match_case(2'b11, 2'b11, DBU_ACC_READ, 32'h104, 2'd0, 1'b0);
    match_case(2'b11, 2'b00, DBU_ACC_WRITE, 32'h0fe, 2'd3, 1'b1);
    match_case(2'b10, 2'b00, DBU_ACC_WRITE, 32'h100, 2'd0, 1'b0);
    match_case(2'b11, 2'b10, DBU_ACC_WRITE, 32'h100, 2'd0, 1'b0);
    // A hit on a disabled slot, then the lock and a single step.
    wr(`DBU_OFF_CONTROL, 32'h0010_0002);
    u_pipe.access(32'h200, DBU_ACC_WRITE, 2'd0);
    run(1'b0, 1'b0, 0, 0);
    rd(`DBU_OFF_STATUS, 32'h0, 1'b0);
    wr(`DBU_OFF_CONTROL, 32'h0010_2002);
    rd(`DBU_OFF_STATUS, 32'h0, 1'b1);
    u_pipe.access(32'h200, DBU_ACC_WRITE, 2'd0);
    run(1'b1, 1'b0, 1, 0);
    rd(`DBU_OFF_CONTROL, 32'h0010_0002, 1'b0);
    rd(`DBU_OFF_STATUS, 32'h0000_4002, 1'b0);
    wr(`DBU_OFF_STATUS, 32'h0);
    // Task switch into a trapped task.
    wr(`DBU_OFF_CONTROL, 32'h0000_00ff);
    u_pipe.tswitch(1'b1);
    rd(`DBU_OFF_CONTROL, 32'h0000_00aa, 1'b0);
    run(1'b0, 1'b0, 1, 0);
    rd(`DBU_OFF_STATUS, 32'h0000_8000, 1'b0);
    wr(`DBU_OFF_STATUS, 32'h0);
    // Breakpoint instruction, then two single steps.
    run(1'b0, 1'b1, 0, 1);
    rd(`DBU_OFF_STATUS, 32'h0, 1'b0);
    run(1'b1, 1'b0, 1, 0);
    run(1'b1, 1'b0, 1, 0);
    rd(`DBU_OFF_STATUS, 32'h0000_4000, 1'b0);
    summarize();
  end
endmodule

`default_nettype wire
